// ==== hw/tmrctl_defines.svh ====
// Purpose: offsets, bit positions and reset values of the timer run/overflow control register
// Assumes: 8-bit special-function-register space, bit addresses = byte address + bit index
// Notes: definitions only
`ifndef TMRCTL_DEFINES_SVH
`define TMRCTL_DEFINES_SVH

`define TMRCTL_CTRL_ADDR 8'h88
`define TMRCTL_CTRL_RESET 8'h00
`define TMRCTL_BIT_T1_OVF 7
`define TMRCTL_BIT_T1_RUN 6
`define TMRCTL_BIT_T0_OVF 5
`define TMRCTL_BIT_T0_RUN 4
`define TMRCTL_BIT_E1_FLAG 3
`define TMRCTL_BIT_E1_TYPE 2
`define TMRCTL_BIT_E0_FLAG 1
`define TMRCTL_BIT_E0_TYPE 0
`define TMRCTL_SYNC_STAGES 2

`endif

// ==== hw/tmrctl_pkg.sv ====
// Purpose: shared types of the timer run/overflow control block
// Assumes: nothing beyond the defines header
// Notes: constants live in tmrctl_defines.svh
package tmrctl_pkg;
	typedef logic [7:0] tmrctl_byte_t;
	typedef logic [1:0] tmrctl_pair_t;
	// trigger kind held in the type-select bits
	typedef enum logic {
		TMRCTL_LEVEL = 1'b0,
		TMRCTL_EDGE = 1'b1
	} tmrctl_trig_t;
endpackage

// ==== hw/tmrctl_eirq_if.sv ====
// Purpose: carries external-interrupt detection between control logic and detector
// Assumes: index 0 is interrupt zero, index 1 is interrupt one
// Notes: trig_event is a level in level mode, a one-cycle pulse in edge mode
`timescale 1ns/100ps
interface tmrctl_eirq_if;
	tmrctl_pkg::tmrctl_pair_t edge_mode;
	tmrctl_pkg::tmrctl_pair_t trig_event;
	modport ctrl (output edge_mode, input trig_event);
	modport det (input edge_mode, output trig_event);
endinterface

// ==== hw/tmrctl_eirq_det.sv ====
// Purpose: synchronise the two external-interrupt pins and detect level or falling edge
// Assumes: pins are active low; polarity selection lies outside this block
// Notes: two-flop synchroniser per pin, edge found on the second flop only
`timescale 1ns/100ps
`include "tmrctl_defines.svh"
module tmrctl_eirq_det #(
	parameter int SYNC_STAGES = `TMRCTL_SYNC_STAGES
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [1:0] pin_n_i,
	tmrctl_eirq_if.det eirq
);
	// the edge finder taps the second flop, so other depths are not served
	if (SYNC_STAGES != 2) begin : g_bad_stages
		$error("tmrctl_eirq_det: only two synchroniser stages are supported");
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_chan
			logic meta_q;
			logic sync_q;
			logic prev_q;
			always_ff @(posedge clk_sys_i or negedge nrst_i) begin
				if (!nrst_i) begin
					meta_q <= 1'b1;
					sync_q <= 1'b1;
					prev_q <= 1'b1;
				end else begin
					meta_q <= pin_n_i[g];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end
			// edge mode: falling edge pulse; level mode: active-low level
			assign eirq.trig_event[g] = eirq.edge_mode[g] ? (prev_q & ~sync_q) : ~sync_q;
		end
	endgenerate
endmodule

// ==== hw/tmrctl_top.sv ====
// Purpose: timer run/overflow control register with external-interrupt flags
// Assumes: overflow and vector strobes come from logic on clk_sys_i, one cycle each
// Notes: byte and single-bit access over the special-function-register bus
// Contract
// - Timer one overflow sets its overflow flag; it stays set until cleared.
// - Timer zero overflow sets its overflow flag; it stays set until cleared.
// - Overflow flags clear by firmware writing zero or on vectoring to their routine.
// - Timer one counts only while its run bit is one.
// - Timer zero counts only while its run bit is one.
// - Eight-bit bit-addressable register at 0x88, fixed bit layout, resets to zero.
// - Interrupt-one flag sets on selected edge or level; edge mode clears on vectoring.
// - Type bit zero means level triggered, one means edge triggered.
`timescale 1ns/100ps
`include "tmrctl_defines.svh"
module tmrctl_top #(
	parameter logic [7:0] CTRL_ADDR = `TMRCTL_CTRL_ADDR
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_bit_addr_i,
	input wire logic sfr_bit_wdata_i,
	input wire logic sfr_bit_wr_i,
	input wire logic sfr_bit_rd_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic timer_zero_ovf_i,
	input wire logic timer_one_ovf_i,
	input wire logic vec_timer_zero_i,
	input wire logic vec_timer_one_i,
	input wire logic vec_ext_irq_zero_i,
	input wire logic vec_ext_irq_one_i,
	input wire logic ext_irq_zero_input_n_i,
	input wire logic ext_irq_one_input_n_i,
	output logic timer_zero_run_o,
	output logic timer_one_run_o,
	output logic timer_zero_overflow_flag_o,
	output logic timer_one_overflow_flag_o,
	output logic ext_irq_zero_flag_o,
	output logic ext_irq_one_flag_o
);
	tmrctl_pkg::tmrctl_byte_t ctrl_img;
	tmrctl_pkg::tmrctl_byte_t wr_en;
	tmrctl_pkg::tmrctl_byte_t wr_val;
	tmrctl_pkg::tmrctl_byte_t rdata_q;
	tmrctl_pkg::tmrctl_byte_t rdata_d;
	logic ext_one_vec_clr;
	logic ext_zero_vec_clr;
	logic bit_rd_val;
	logic byte_hit;
	logic bit_hit;
	logic [2:0] bit_idx;
	logic timer_one_overflow_flag_q;
	logic timer_one_run_q;
	logic timer_zero_overflow_flag_q;
	logic timer_zero_run_q;
	logic ext_irq_one_flag_q;
	logic ext_irq_one_type_q;
	logic ext_irq_zero_flag_q;
	logic ext_irq_zero_type_q;

	tmrctl_eirq_if eirq ();

	tmrctl_eirq_det #(
		.SYNC_STAGES(`TMRCTL_SYNC_STAGES)
	) u_det (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.pin_n_i({ext_irq_one_input_n_i, ext_irq_zero_input_n_i}),
		.eirq(eirq)
	);

	assign eirq.edge_mode = {ext_irq_one_type_q, ext_irq_zero_type_q};

	// vectoring clears an external flag only in edge mode; level flags are firmware's
	assign ext_one_vec_clr = vec_ext_irq_one_i && ext_irq_one_type_q;
	assign ext_zero_vec_clr = vec_ext_irq_zero_i && ext_irq_zero_type_q;

	// bit addressing needs the register on an eight-byte boundary
	if (CTRL_ADDR[2:0] != 3'h0) begin : g_bad_addr
		$error("tmrctl_top: control register must sit on an eight-byte boundary");
	end

	// bit addresses CTRL_ADDR..CTRL_ADDR+7 map onto bits 0..7
	assign byte_hit = (sfr_addr_i == CTRL_ADDR);
	assign bit_hit = (sfr_bit_addr_i[7:3] == CTRL_ADDR[7:3]);
	assign bit_idx = sfr_bit_addr_i[2:0];

	always_comb begin
		wr_en = 8'h00;
		wr_val = ctrl_img;
		if (sfr_wr_i && byte_hit) begin
			wr_en = 8'hFF;
			wr_val = sfr_wdata_i;
		end else if (sfr_bit_wr_i && bit_hit) begin
			wr_en[bit_idx] = 1'b1;
			wr_val[bit_idx] = sfr_bit_wdata_i;
		end
	end

	// register image assembled from the position defines
	always_comb begin
		ctrl_img = 8'h00;
		ctrl_img[`TMRCTL_BIT_T1_OVF] = timer_one_overflow_flag_q;
		ctrl_img[`TMRCTL_BIT_T1_RUN] = timer_one_run_q;
		ctrl_img[`TMRCTL_BIT_T0_OVF] = timer_zero_overflow_flag_q;
		ctrl_img[`TMRCTL_BIT_T0_RUN] = timer_zero_run_q;
		ctrl_img[`TMRCTL_BIT_E1_FLAG] = ext_irq_one_flag_q;
		ctrl_img[`TMRCTL_BIT_E1_TYPE] = ext_irq_one_type_q;
		ctrl_img[`TMRCTL_BIT_E0_FLAG] = ext_irq_zero_flag_q;
		ctrl_img[`TMRCTL_BIT_E0_TYPE] = ext_irq_zero_type_q;
	end

	// set first: an overflow in the clearing cycle must not be lost
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			timer_one_overflow_flag_q <= 1'b0;
		else if (timer_one_ovf_i)
			timer_one_overflow_flag_q <= 1'b1;
		else if (vec_timer_one_i)
			timer_one_overflow_flag_q <= 1'b0;
		else if (wr_en[`TMRCTL_BIT_T1_OVF])
			timer_one_overflow_flag_q <= wr_val[`TMRCTL_BIT_T1_OVF];
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			timer_zero_overflow_flag_q <= 1'b0;
		else if (timer_zero_ovf_i)
			timer_zero_overflow_flag_q <= 1'b1;
		else if (vec_timer_zero_i)
			timer_zero_overflow_flag_q <= 1'b0;
		else if (wr_en[`TMRCTL_BIT_T0_OVF])
			timer_zero_overflow_flag_q <= wr_val[`TMRCTL_BIT_T0_OVF];
	end

	// run bits change only by firmware; a timer stops on the edge after the clear
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			timer_one_run_q <= 1'b0;
		else if (wr_en[`TMRCTL_BIT_T1_RUN])
			timer_one_run_q <= wr_val[`TMRCTL_BIT_T1_RUN];
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			timer_zero_run_q <= 1'b0;
		else if (wr_en[`TMRCTL_BIT_T0_RUN])
			timer_zero_run_q <= wr_val[`TMRCTL_BIT_T0_RUN];
	end

	// a type change steers the detector from the following edge on
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			ext_irq_one_type_q <= 1'b0;
		else if (wr_en[`TMRCTL_BIT_E1_TYPE])
			ext_irq_one_type_q <= wr_val[`TMRCTL_BIT_E1_TYPE];
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			ext_irq_zero_type_q <= 1'b0;
		else if (wr_en[`TMRCTL_BIT_E0_TYPE])
			ext_irq_zero_type_q <= wr_val[`TMRCTL_BIT_E0_TYPE];
	end

	// in level mode the flag re-sets while the input stays active
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			ext_irq_one_flag_q <= 1'b0;
		else if (eirq.trig_event[1])
			ext_irq_one_flag_q <= 1'b1;
		else if (ext_one_vec_clr)
			ext_irq_one_flag_q <= 1'b0;
		else if (wr_en[`TMRCTL_BIT_E1_FLAG])
			ext_irq_one_flag_q <= wr_val[`TMRCTL_BIT_E1_FLAG];
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			ext_irq_zero_flag_q <= 1'b0;
		else if (eirq.trig_event[0])
			ext_irq_zero_flag_q <= 1'b1;
		else if (ext_zero_vec_clr)
			ext_irq_zero_flag_q <= 1'b0;
		else if (wr_en[`TMRCTL_BIT_E0_FLAG])
			ext_irq_zero_flag_q <= wr_val[`TMRCTL_BIT_E0_FLAG];
	end

	// byte read wins over a same-cycle bit read; unmapped reads give zero
	assign bit_rd_val = bit_hit & ctrl_img[bit_idx];

	always_comb begin
		rdata_d = rdata_q;
		if (sfr_rd_i)
			rdata_d = byte_hit ? ctrl_img : 8'h00;
		else if (sfr_bit_rd_i)
			rdata_d = {7'h00, bit_rd_val};
	end

	// held until the next read strobe, so the core may sample it late
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			rdata_q <= `TMRCTL_CTRL_RESET;
		else
			rdata_q <= rdata_d;
	end

	assign sfr_rdata_o = rdata_q;
	assign timer_one_run_o = timer_one_run_q;
	assign timer_zero_run_o = timer_zero_run_q;
	assign timer_one_overflow_flag_o = timer_one_overflow_flag_q;
	assign timer_zero_overflow_flag_o = timer_zero_overflow_flag_q;
	assign ext_irq_one_flag_o = ext_irq_one_flag_q;
	assign ext_irq_zero_flag_o = ext_irq_zero_flag_q;
endmodule

// ==== sim/tmrctl_top_properties.sv ====
// Purpose: port timing of the timer control register
// Assumes: strobes one cycle wide
// Notes: bound into tmrctl_top
`timescale 1ns/100ps
module tmrctl_top_properties (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic timer_zero_ovf_i,
	input wire logic timer_one_ovf_i,
	input wire logic vec_timer_zero_i,
	input wire logic vec_timer_one_i,
	input wire logic timer_zero_run_o,
	input wire logic timer_one_run_o,
	input wire logic timer_zero_overflow_flag_o,
	input wire logic timer_one_overflow_flag_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	wire hit = sfr_addr_i == 8'h88;
	wire [3:0] vis = {timer_one_overflow_flag_o, timer_one_run_o,
		timer_zero_overflow_flag_o, timer_zero_run_o};
	a_t1_ovf_set: assert property (timer_one_ovf_i |=> timer_one_overflow_flag_o)
		else $error("t1 flag not set");
	a_t0_ovf_set: assert property (timer_zero_ovf_i |=> timer_zero_overflow_flag_o)
		else $error("t0 flag not set");
	a_t1_vec_clr: assert property (vec_timer_one_i && !timer_one_ovf_i
		|=> !timer_one_overflow_flag_o) else $error("t1 flag kept");
	a_t0_vec_clr: assert property (vec_timer_zero_i && !timer_zero_ovf_i
		|=> !timer_zero_overflow_flag_o) else $error("t0 flag kept");
	a_t1_run_wr: assert property (sfr_wr_i && hit
		|=> timer_one_run_o == $past(sfr_wdata_i[6])) else $error("t1 run");
	a_t0_run_wr: assert property (sfr_wr_i && hit
		|=> timer_zero_run_o == $past(sfr_wdata_i[4])) else $error("t0 run");
	a_rd_data: assert property (sfr_rd_i && hit
		|=> sfr_rdata_o[7:4] == $past(vis)) else $error("read data");
	a_rd_unmap: assert property (sfr_rd_i && !hit |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read");
endmodule
bind tmrctl_top tmrctl_top_properties i_chk (.clk_sys_i, .nrst_i, .sfr_addr_i, .sfr_wdata_i,
	.sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .timer_zero_ovf_i, .timer_one_ovf_i, .vec_timer_zero_i,
	.vec_timer_one_i, .timer_zero_run_o, .timer_one_run_o, .timer_zero_overflow_flag_o,
	.timer_one_overflow_flag_o);

// ==== sim/tmrctl_cpu_model.sv ====
// Purpose: processor side of the register bus
// Assumes: one access at a time
// Notes: idle address and write-data lines show the inverse of the last access; the bit write-data line keeps its value
`timescale 1ns/100ps
module tmrctl_cpu_model (
	input wire logic clk_sys_i,
	output logic [7:0] sfr_addr_o = 8'h00,
	output logic [7:0] sfr_wdata_o = 8'h00,
	output logic [7:0] sfr_bit_addr_o = 8'h00,
	output logic sfr_bit_wdata_o = 1'b0,
	output logic [3:0] sfr_strb_o = 4'h0
);
	// k is {bit_rd, bit_wr, rd, wr}; a zero write clears a flag
	task op(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i) #1;
		sfr_strb_o = k;
		sfr_addr_o = a;
		sfr_bit_addr_o = a;
		sfr_wdata_o = d;
		sfr_bit_wdata_o = d[0];
		@(posedge clk_sys_i) #1;
		sfr_strb_o = 4'h0;
		sfr_addr_o = ~a;
		sfr_bit_addr_o = ~a;
		sfr_wdata_o = ~d;
	endtask
endmodule

// ==== sim/tmrctl_tb_top.sv ====
// Purpose: self-checking bench of the timer control register
// Assumes: pins idle high
// Notes: random traffic plus event corners
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tmrctl_tb_top;
	logic clk_sys_i = 0;
	logic nrst_i = 0;
	logic [7:0] ev = 8'hC0, a, d, m, sfr_addr_o, sfr_wdata_o, sfr_bit_addr_o, sfr_rdata_o;
	logic [3:0] sfr_strb_o, f;
	logic sfr_bit_wdata_o, timer_zero_run_o, timer_one_run_o;
	int n_mismatch = 0;
	int samples_checked = 0;
	initial forever #4 clk_sys_i = ~clk_sys_i;
	tmrctl_cpu_model i_cpu (.clk_sys_i, .sfr_addr_o, .sfr_wdata_o, .sfr_bit_addr_o,
		.sfr_bit_wdata_o, .sfr_strb_o);
	tmrctl_top i_dut (.clk_sys_i, .nrst_i, .sfr_addr_i(sfr_addr_o), .sfr_wdata_i(sfr_wdata_o),
		.sfr_wr_i(sfr_strb_o[0]), .sfr_rd_i(sfr_strb_o[1]), .sfr_bit_addr_i(sfr_bit_addr_o),
		.sfr_bit_wdata_i(sfr_bit_wdata_o), .sfr_bit_wr_i(sfr_strb_o[2]),
		.sfr_bit_rd_i(sfr_strb_o[3]), .sfr_rdata_o, .timer_zero_ovf_i(ev[0]),
		.timer_one_ovf_i(ev[1]), .vec_timer_zero_i(ev[2]), .vec_timer_one_i(ev[3]),
		.vec_ext_irq_zero_i(ev[4]), .vec_ext_irq_one_i(ev[5]), .ext_irq_zero_input_n_i(ev[6]),
		.ext_irq_one_input_n_i(ev[7]), .timer_zero_run_o, .timer_one_run_o,
		.timer_zero_overflow_flag_o(f[0]), .timer_one_overflow_flag_o(f[1]),
		.ext_irq_zero_flag_o(f[2]), .ext_irq_one_flag_o(f[3]));
	function automatic logic [7:0] rd_exp(input logic [7:0] a, input logic [7:0] m);
		return (a == 8'h88) ? m : 8'h00;
	endfunction
	task ev_pulse(input logic [7:0] v);
		@(posedge clk_sys_i) #1;
		ev = ev ^ v;
		@(posedge clk_sys_i) #1;
		ev = ev ^ v;
	endtask
	task conclude;
		if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#50000;
		n_mismatch++;
		conclude();
	end
	initial begin
		void'($urandom(32'h9A9D42C3));
		repeat (5) @(posedge clk_sys_i);
		#1 nrst_i = 1;
		m = 8'h00;
		`CHK("reset flags", 4'h0, f)
		`CHK("reset run", 2'h0, {timer_one_run_o, timer_zero_run_o})
		i_cpu.op(4'h2, 8'h88, 8'h00);
		`CHK("reset read", 8'h00, sfr_rdata_o)
		repeat (24) begin
			a = 8'($urandom_range(8'h8A, 8'h86));
			d = 8'($urandom);
			i_cpu.op(4'h1, a, d);
			m = (a == 8'h88) ? d : m;
			i_cpu.op(4'h2, a, 8'h00);
			`CHK("read", rd_exp(a, m), sfr_rdata_o)
			`CHK("run", {m[6], m[4]}, {timer_one_run_o, timer_zero_run_o})
			a = 8'h88 + 8'($urandom_range(7, 0));
			i_cpu.op(4'h4, a, d >> 7);
			m[a[2:0]] = d[7];
			i_cpu.op(4'h8, a, 8'h00);
			`CHK("bit", {7'h00, m[a[2:0]]}, sfr_rdata_o)
		end
		for (int i = 0; i < 2; i++) begin
			// set and clear land on one edge
			fork
				i_cpu.op(4'h1, 8'h88, 8'h00);
				ev_pulse(8'h01 << i);
			join
			`CHK("ovf", 1'b1, f[i])
			ev_pulse(8'h04 << i);
			`CHK("vec", 1'b0, f[i])
			i_cpu.op(4'h4, 8'(8'h88 + 2 * i), 8'h01);
			ev_pulse(8'h40 << i);
			#40;
			`CHK("edge", 1'b1, f[2 + i])
			ev_pulse(8'h10 << i);
			`CHK("evec", 1'b0, f[2 + i])
			i_cpu.op(4'h4, 8'(8'h88 + 2 * i), 8'h00);
			ev = ev ^ (8'h40 << i);
			#40;
			ev_pulse(8'h10 << i);
			`CHK("level", 1'b1, f[2 + i])
			ev = ev ^ (8'h40 << i);
		end
		conclude();
	end
endmodule
